// file: testbench/gpl_host.sv
// Register request model of the bus engine.
`timescale 1ns/1ps
module gpl_host
  import gpl_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output gpl_pkg::gpl_reg_req_type req_out
);
  initial req_out = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_in);
    req_out = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: v};
    @(negedge clk_in);
    req_out = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_in);
    req_out = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(negedge clk_in);
    req_out = '0;
    v = rdata_in;
  endtask : rd
endmodule : gpl_host

// file: testbench/gpl_pins_asserts.sv
// Port checker for the pin block.
`timescale 1ns/1ps
module gpl_pins_asserts
  import gpl_pkg::*;
#(
  parameter logic [7:0] PRODUCT_CODE = 8'hA5,
  parameter logic [7:0] MAKER_CODE = 8'h3C,
  parameter logic [7:0] REVISION_CODE = 8'h01
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire gpl_pkg::gpl_reg_req_type reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic fan_drive_a_level_in,
  input wire logic fan_drive_a_active_in,
  input wire logic fan_drive_a_output_out,
  input wire logic fan_drive_a_oe_out,
  input wire logic alert_mask_in,
  input wire logic alert_out,
  input wire logic pin_status_summary_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence rd_at(logic [7:0] a);
    reg_req_in.rd && reg_req_in.addr == a;
  endsequence
  fan_follow_a:
    assert property (fan_drive_a_active_in |=>
      fan_drive_a_output_out == $past(fan_drive_a_level_in))
    else $error("fan drive value wrong");
  fan_release_a:
    assert property (!fan_drive_a_active_in |=> !fan_drive_a_oe_out)
    else $error("fan pin driven while idle");
  alert_cause_a:
    assert property (alert_out |-> $past(pin_status_summary_out))
    else $error("alert without a change flag");
  mask_blocks_a:
    assert property (alert_mask_in |=> !alert_out)
    else $error("alert while masked");
  flag_clear_a:
    assert property ($fell(pin_status_summary_out) |->
      $past(reg_req_in.rd) && $past(reg_req_in.addr) == 8'hE6)
    else $error("flags cleared without a read");
  rdata_hold_a:
    assert property (!reg_req_in.rd |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  product_id_a:
    assert property (rd_at(8'hFD) |=> reg_rdata_out == PRODUCT_CODE)
    else $error("product code wrong");
  maker_id_a:
    assert property (rd_at(8'hFE) |=> reg_rdata_out == MAKER_CODE)
    else $error("maker code wrong");
  revision_id_a:
    assert property (rd_at(8'hFF) |=> reg_rdata_out == REVISION_CODE)
    else $error("revision code wrong");
endmodule : gpl_pins_asserts
bind gpl_pins gpl_pins_asserts #(.PRODUCT_CODE(PRODUCT_CODE),
  .MAKER_CODE(MAKER_CODE), .REVISION_CODE(REVISION_CODE))
  gpl_pins_asserts_inst (.*);

// file: testbench/gpl_pins_test.sv
// Self-checking bench for the pin block.
`timescale 1ns/1ps
module gpl_pins_test;
  import gpl_pkg::*;
  logic clk_in = 0;
  logic rstn_in = 0;
  gpl_reg_req_type req;
  logic [7:0] rdata, d;
  logic [2:0] ext = 3'h7, lvl, drv, oe, fsel;
  logic fan_lvl = 0, fan_act = 0, fan_out, fan_oe, mask = 0, alert, summ;
  gpl_strap_cfg_type scfg;
  int n_mismatch = 0, checks_done = 0, cyc = 0, i;
  logic [7:0] ra [13] = '{8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5,
    8'hE6, 8'hEF, 8'hFC, 8'hFD, 8'hFE, 8'hFF, 8'h80};
  logic [7:0] rv [13] = '{8'h01, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h01, 8'hA5, 8'h3C, 8'h01, 8'h00};
  // Released pins are pulled up by the external resistor.
  assign lvl = (oe & drv) | (~oe & ext);
  always #5 clk_in = ~clk_in;
  gpl_host gpl_host_inst (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
  gpl_pins gpl_pins_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .reg_req_in(req), .reg_rdata_out(rdata), .pin_level_in(lvl),
    .pin_drive_out(drv), .pin_oe_out(oe), .fan_drive_a_level_in(fan_lvl),
    .fan_drive_a_active_in(fan_act), .fan_drive_a_output_out(fan_out),
    .fan_drive_a_oe_out(fan_oe), .shutdown_strap_select_in(2'h1),
    .alert_mask_in(mask), .alert_out(alert),
    .pin_status_summary_out(summ), .strap_cfg_out(scfg),
    .pin_function_out(fsel));
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic rc(logic [7:0] a, logic [7:0] e);
    logic [7:0] v;
    gpl_host_inst.rd(a, v);
    chk($sformatf("reg %h", a), {1'h0, e}, {1'h0, v});
  endtask : rc
  task automatic pause(int n);
    repeat (n) @(negedge clk_in);
  endtask : pause
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  initial
  begin
    pause(8);
    rstn_in = 1;
    for (i = 0; i < 13; i++)
      rc(ra[i], rv[i]);
    chk("strap", 9'h078, scfg);
    $display("reset values done");
    gpl_host_inst.wr(8'hE0, 8'h07);
    gpl_host_inst.wr(8'hE1, 8'h07);
    gpl_host_inst.wr(8'hE2, 8'h41);
    gpl_host_inst.wr(8'hE4, 8'h05);
    pause(4);
    chk("function", 9'h007, fsel);
    chk("pin oe", 9'h003, oe);
    chk("pin drive", 9'h001, drv & oe);
    rc(8'hE2, 8'h41);
    rc(8'hE3, 8'h05);
    fan_act = 1;
    fan_lvl = 1;
    pause(2);
    chk("fan push pull", 9'h001, fan_oe);
    chk("fan value", 9'h001, fan_out);
    gpl_host_inst.wr(8'hE2, 8'h01);
    pause(2);
    chk("fan open drain", 9'h000, fan_oe);
    fan_act = 0;
    $display("outputs done");
    gpl_host_inst.wr(8'hE1, 8'h00);
    gpl_host_inst.wr(8'hE5, 8'h07);
    pause(6);
    gpl_host_inst.rd(8'hE6, d);
    ext[1] = 0;
    pause(6);
    chk("summary", 9'h001, summ);
    chk("alert on", 9'h001, alert);
    rc(8'hE6, 8'h02);
    rc(8'hE6, 8'h00);
    mask = 1;
    ext[1] = 1;
    pause(6);
    chk("alert masked", 9'h000, alert);
    rc(8'hE6, 8'h02);
    mask = 0;
    gpl_host_inst.wr(8'hE5, 8'h06);
    ext[0] = 0;
    pause(6);
    chk("alert disabled", 9'h000, alert);
    rc(8'hE6, 8'h01);
    gpl_host_inst.wr(8'hE0, 8'h00);
    ext[2] = 0;
    pause(6);
    chk("function off", 9'h000, fsel);
    rc(8'hE6, 8'h00);
    $display("change flags done");
    gpl_host_inst.wr(8'hEF, 8'h01);
    gpl_host_inst.wr(8'hE5, 8'h07);
    rc(8'hE5, 8'h06);
    gpl_host_inst.wr(8'hEF, 8'h00);
    rc(8'hEF, 8'h01);
    gpl_host_inst.wr(8'hFD, 8'h00);
    rc(8'hFD, 8'hA5);
    $display("lock done");
    rstn_in = 0;
    pause(8);
    rstn_in = 1;
    rc(8'hEF, 8'h00);
    rc(8'hE6, 8'h00);
    gpl_host_inst.wr(8'hE5, 8'h07);
    rc(8'hE5, 8'h07);
    $display("hard reset unlock done");
    final_report();
  end
endmodule : gpl_pins_test

// file: verilog/gpl_defines.svh
// Register offsets, field positions, reset values and codes for the pin block.
`ifndef GPL_DEFINES_SVH
`define GPL_DEFINES_SVH
`define GPL_ADDR_FUNC_SEL 8'hE0
`define GPL_ADDR_DIRECTION 8'hE1
`define GPL_ADDR_OUT_TYPE 8'hE2
`define GPL_ADDR_IN_LEVELS 8'hE3
`define GPL_ADDR_OUT_VALUES 8'hE4
`define GPL_ADDR_ALERT_EN 8'hE5
`define GPL_ADDR_CHG_FLAGS 8'hE6
`define GPL_ADDR_LOCK 8'hEF
`define GPL_ADDR_STRAP 8'hFC
`define GPL_ADDR_PRODUCT 8'hFD
`define GPL_ADDR_MAKER 8'hFE
`define GPL_ADDR_REVISION 8'hFF
`define GPL_RST_FUNC_SEL 8'h01
`define GPL_RST_DIRECTION 8'h00
`define GPL_RST_OUT_TYPE 8'h00
`define GPL_RST_OUT_VALUES 8'h00
`define GPL_RST_ALERT_EN 8'h00
`define GPL_RST_LOCK 8'h00
`define GPL_BIT_FAN_A_OT 6
`define GPL_BIT_LOCK 0
`define GPL_STRAP_TRANSISTOR 2'h0
`define GPL_STRAP_DIODE 2'h1
`define GPL_STRAP_INTERNAL 2'h2
`define GPL_FIXED_BETA 4'hF
`endif

// file: verilog/gpl_pins.sv
// General-purpose pins with change flags, write lock, strap and identity.
//
// How it works
// [R1] Fan drive output is open drain when its type bit is 0, push-pull at 1.
// [R2] Each pin uses open drain at type 0 and push-pull at type 1.
// [R3] Output type applies in general-purpose output or fan drive role.
// [R4] Input register returns present pin levels regardless of function.
// [R5] Level change on an alert-enabled general-purpose input raises alert unless masked.
// [R6] Open drain: bit 1 releases the pin, bit 0 drives low.
// [R7] Push-pull: pin follows the output bit right after it is written.
// [R8] Output bit acts only when the pin is general-purpose and output.
// [R9] Per-pin alert enable lets a change raise the alert.
// [R10] Alert enable ignored when pin is not a general-purpose input.
// [R11] Change flag sets on every edge of a general-purpose input.
// [R12] Change flags stay set until the flag register is read.
// [R13] Summary status bit is high while any change flag is set.
// [R14] Lock bit makes lockable registers read-only until hard reset.
// [R15] The lock register is itself lockable.
// [R16] Strap register shows the two-bit shutdown strap state.
// [R17] Strap code selects diode mode, beta, correction and shutdown range.
// [R18] Product code register is fixed read-only.
// [R19] Maker code register is fixed read-only.
// [R20] Die revision register is fixed read-only.
// [R21] Direction bit 0 is input, 1 output, ignored outside pin function.
// [R22] Function select 1 makes the shared pin general-purpose.
// [R23] An edge during a flag read stays flagged.
// [R24] Pin inputs are synchronised before edge detection.
`timescale 1ns/1ps
`include "gpl_defines.svh"
module gpl_pins #(
  parameter int NUM_PINS = 3,
  parameter logic [7:0] PRODUCT_CODE = 8'hA5,
  parameter logic [7:0] MAKER_CODE = 8'h3C,
  parameter logic [7:0] REVISION_CODE = 8'h01
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire gpl_pkg::gpl_reg_req_type reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [NUM_PINS-1:0] pin_level_in,
  output logic [NUM_PINS-1:0] pin_drive_out,
  output logic [NUM_PINS-1:0] pin_oe_out,
  input wire logic fan_drive_a_level_in,
  input wire logic fan_drive_a_active_in,
  output logic fan_drive_a_output_out,
  output logic fan_drive_a_oe_out,
  input wire logic [1:0] shutdown_strap_select_in,
  input wire logic alert_mask_in,
  output logic alert_out,
  output logic pin_status_summary_out,
  output gpl_pkg::gpl_strap_cfg_type strap_cfg_out,
  output logic [NUM_PINS-1:0] pin_function_out
);
  import gpl_pkg::*;

  // Registers hold three pin bits; the upper bits are not implemented, except the fan output type bit 6 of the output type register.
  if (NUM_PINS != 3)
  begin : g_bad_pin_count
    $error("gpl_pins supports exactly three pins");
  end

  logic [NUM_PINS-1:0] pin_a_function_select;
  logic [NUM_PINS-1:0] pin_direction;
  logic [NUM_PINS-1:0] pin_output_type;
  logic fan_drive_a_output_type;
  logic [NUM_PINS-1:0] pin_output_value;
  logic [NUM_PINS-1:0] pin_change_alert_enable;
  logic [NUM_PINS-1:0] pin_change_flag;
  logic lock;
  logic [NUM_PINS-1:0] sync_meta;
  logic [NUM_PINS-1:0] pin_input_level;
  logic [NUM_PINS-1:0] prev_level;
  logic started;
  logic [1:0] warm_count;
  logic [1:0] strap_state;
  logic strap_taken;
  logic [NUM_PINS-1:0] gp_output;
  logic [NUM_PINS-1:0] gp_input;
  logic [NUM_PINS-1:0] edge_seen;
  logic flag_read;
  logic reg_wr_ok;

  assign reg_wr_ok = reg_req_in.wr && !lock; // [R14] [R15]
  assign flag_read = reg_req_in.rd &&
                     (reg_req_in.addr == `GPL_ADDR_CHG_FLAGS);
  assign gp_output = pin_a_function_select & pin_direction; // [R21] [R22]
  assign gp_input = pin_a_function_select & ~pin_direction; // [R10]

  // Control registers, all frozen by the lock bit.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      pin_a_function_select <= NUM_PINS'(`GPL_RST_FUNC_SEL);
      pin_direction <= NUM_PINS'(`GPL_RST_DIRECTION);
      pin_output_type <= NUM_PINS'(`GPL_RST_OUT_TYPE);
      fan_drive_a_output_type <= 1'b0;
      pin_output_value <= NUM_PINS'(`GPL_RST_OUT_VALUES);
      pin_change_alert_enable <= NUM_PINS'(`GPL_RST_ALERT_EN);
      lock <= 1'b0;
    end
    else if (reg_wr_ok)
    begin
      case (reg_req_in.addr)
        `GPL_ADDR_FUNC_SEL:
          pin_a_function_select <= reg_req_in.wdata[NUM_PINS-1:0]; // [R22]
        `GPL_ADDR_DIRECTION:
          pin_direction <= reg_req_in.wdata[NUM_PINS-1:0]; // [R21]
        `GPL_ADDR_OUT_TYPE:
        begin
          pin_output_type <= reg_req_in.wdata[NUM_PINS-1:0]; // [R2]
          fan_drive_a_output_type <=
            reg_req_in.wdata[`GPL_BIT_FAN_A_OT]; // [R1]
        end
        `GPL_ADDR_OUT_VALUES:
          pin_output_value <= reg_req_in.wdata[NUM_PINS-1:0];
        `GPL_ADDR_ALERT_EN:
          pin_change_alert_enable <= reg_req_in.wdata[NUM_PINS-1:0]; // [R9]
        `GPL_ADDR_LOCK:
          lock <= reg_req_in.wdata[`GPL_BIT_LOCK]; // [R14]
        default:
        begin
        end
      endcase
    end
  end

  // Two-stage synchroniser, then a held copy for edge comparison.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      sync_meta <= '0;
      pin_input_level <= '0;
      prev_level <= '0;
      warm_count <= 2'h0;
    end
    else
    begin
      sync_meta <= pin_level_in; // [R24]
      pin_input_level <= sync_meta; // [R24]
      prev_level <= pin_input_level;
      if (warm_count != 2'h3)
      begin
        warm_count <= warm_count + 2'h1;
      end
    end
  end

  // Compares wait until both held copies carry real pin levels.
  // Otherwise the zero left by reset would look like an edge.
  assign started = (warm_count == 2'h3);

  assign edge_seen = (pin_input_level ^ prev_level) & gp_input &
                     {NUM_PINS{started}}; // [R11]

  // Change flags: set wins over the clear that a read performs.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      pin_change_flag <= '0;
    end
    else if (flag_read)
    begin
      pin_change_flag <= edge_seen; // [R12] [R23]
    end
    else
    begin
      pin_change_flag <= pin_change_flag | edge_seen; // [R11] [R12]
    end
  end

  // Alert follows flags of enabled general-purpose inputs.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      alert_out <= 1'b0;
    end
    else
    begin
      alert_out <= !alert_mask_in &&
                   |(pin_change_flag & pin_change_alert_enable &
                     gp_input); // [R5] [R9] [R10]
    end
  end

  assign pin_status_summary_out = |pin_change_flag; // [R13]

  // Strap level is caught once after reset release.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      strap_state <= 2'h0;
      strap_taken <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_state <= shutdown_strap_select_in; // [R16]
      strap_taken <= 1'b1;
    end
  end

  always_comb
  begin
    strap_cfg_out = '0;
    case (strap_state)
      `GPL_STRAP_TRANSISTOR:
      begin
        strap_cfg_out.transistor_mode = 1'b1; // [R17]
        strap_cfg_out.auto_beta = 1'b1;
        strap_cfg_out.error_correction = 1'b1;
        strap_cfg_out.high_range = 1'b1;
      end
      `GPL_STRAP_DIODE:
        strap_cfg_out.fixed_beta = `GPL_FIXED_BETA; // [R17]
      `GPL_STRAP_INTERNAL:
        strap_cfg_out.internal_diode = 1'b1; // [R17]
      default:
        strap_cfg_out = '0;
    endcase
  end

  // Pin drivers.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1)
    begin : g_pin
      always_ff @(posedge clk_in)
      begin
        if (!rstn_in)
        begin
          pin_drive_out[gi] <= 1'b0;
          pin_oe_out[gi] <= 1'b0;
        end
        else if (gp_output[gi]) // [R8] [R3]
        begin
          pin_drive_out[gi] <= pin_output_value[gi]; // [R7]
          pin_oe_out[gi] <= pin_output_type[gi] ||
                            !pin_output_value[gi]; // [R2] [R6]
        end
        else
        begin
          pin_drive_out[gi] <= 1'b0;
          pin_oe_out[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Fan drive pin; driven while fan_drive_a_active_in is high, at push-pull or with level low at open drain, whatever the function select.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      fan_drive_a_output_out <= 1'b0;
      fan_drive_a_oe_out <= 1'b0;
    end
    else
    begin
      fan_drive_a_output_out <= fan_drive_a_level_in;
      fan_drive_a_oe_out <= fan_drive_a_active_in &&
                            (fan_drive_a_output_type ||
                             !fan_drive_a_level_in); // [R1] [R3]
    end
  end

  assign pin_function_out = pin_a_function_select;

  // Read data, registered.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      reg_rdata_out <= 8'h00;
    end
    else if (reg_req_in.rd)
    begin
      case (reg_req_in.addr)
        `GPL_ADDR_FUNC_SEL: reg_rdata_out <= 8'(pin_a_function_select);
        `GPL_ADDR_DIRECTION: reg_rdata_out <= 8'(pin_direction);
        `GPL_ADDR_OUT_TYPE:
          reg_rdata_out <= {1'b0, fan_drive_a_output_type, 3'b000,
                            pin_output_type};
        `GPL_ADDR_IN_LEVELS: reg_rdata_out <= 8'(pin_input_level); // [R4]
        `GPL_ADDR_OUT_VALUES: reg_rdata_out <= 8'(pin_output_value);
        `GPL_ADDR_ALERT_EN: reg_rdata_out <= 8'(pin_change_alert_enable);
        `GPL_ADDR_CHG_FLAGS: reg_rdata_out <= 8'(pin_change_flag);
        `GPL_ADDR_LOCK: reg_rdata_out <= {7'h00, lock};
        `GPL_ADDR_STRAP: reg_rdata_out <= {6'h00, strap_state}; // [R16]
        `GPL_ADDR_PRODUCT: reg_rdata_out <= PRODUCT_CODE; // [R18]
        `GPL_ADDR_MAKER: reg_rdata_out <= MAKER_CODE; // [R19]
        `GPL_ADDR_REVISION: reg_rdata_out <= REVISION_CODE; // [R20]
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule : gpl_pins

// file: verilog/gpl_pkg.sv
// Types shared by the pin block and its bench.
package gpl_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gpl_reg_req_type;
  typedef struct packed {
    logic transistor_mode;
    logic auto_beta;
    logic [3:0] fixed_beta;
    logic error_correction;
    logic high_range;
    logic internal_diode;
  } gpl_strap_cfg_type;
endpackage : gpl_pkg
